// file: rcp_pkg.sv
// package: constants shared by both ends of the regulator control port
package rcp_pkg;
  localparam logic [7:0] REG_SHARED_CTRL = 8'h00;
  localparam logic [7:0] REG_CH1_VMODE = 8'h01;
  localparam logic [7:0] REG_CH2_VMODE_POR = 8'h02;
  localparam logic [7:0] RESET_SHARED_CTRL = 8'h00;
  localparam logic [7:0] RESET_CH1 = 8'h00;
  localparam logic [7:0] RESET_CH2 = 8'h00;
  // arbitrary neutral device address
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam int CLK_MHZ = 50;
  localparam int LINK_KHZ = 400;
  localparam int HALF_CYCLES = (CLK_MHZ * 1000) / (LINK_KHZ * 2);
  // apb map of the master end
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_WDATA = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_RDATA = 8'h0C;
  localparam int CMD_GO = 0;
  localparam int CMD_READ = 1;
  localparam int CMD_PTR_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
endpackage : rcp_pkg

// file: rcp_link_if.sv
// interface: two-wire link between master and device
`timescale 1ns/1ns
interface rcp_link_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_d;
  logic sda_oe_d;
  wire scl = scl_oe_m ? scl_o_m : 1'b1;
  wire sda = (sda_oe_m && !sda_o_m) || (sda_oe_d && !sda_o_d) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_o_d, output sda_oe_d);
  modport master (input scl, input sda, output scl_o_m, output scl_oe_m,
                  output sda_o_m, output sda_oe_m);
endinterface : rcp_link_if

// file: rcp_device.sv
// device end: two-wire slave holding three regulator registers
`timescale 1ns/1ns
// Overview of operation
// - data changes only while clock low
// - start is data fall, clock high
// - stop is data rise, clock high
// - only the master makes start, stop
// - bus busy from start until stop
// - repeated start restarts address reception
// - master clocks the acknowledge pulse
// - sender releases data during acknowledge
// - addressed receiver pulls ninth bit low
// - first byte: seven-bit address, direction bit
// - second write byte sets register pointer
// - third write byte stored at pointer
// - master writes pointer before reading
// - three registers at 00, 01, 02
module rcp_device (
  // system
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // link
  rcp_link_if.device link,
  // register contents and bus busy flag
  output logic [7:0] o_shared_ctrl,
  output logic [7:0] o_ch1_vmode,
  output logic [7:0] o_ch2_vmode_por,
  output logic o_bus_busy
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_DATA, S_SEND, S_IGN} rcp_state_e;
  logic [2:0] scl_sync_reg, sda_sync_reg;
  rcp_state_e state_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg, ptr_reg;
  logic [7:0] ctrl_reg, ch1_reg, ch2_reg;
  logic sda_low_reg, busy_reg, dir_reg, got_ptr_reg, ack_ok_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      scl_sync_reg <= 3'b111;
      sda_sync_reg <= 3'b111;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], link.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], link.sda};
    end
  end
  // stages [1] and [2] only: [0] is the first synchroniser flop
  wire scl_hi = scl_sync_reg[1];
  wire scl_rise = scl_sync_reg[1] && !scl_sync_reg[2];
  wire scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
  wire start_det = scl_hi && scl_sync_reg[2] && !sda_sync_reg[1] && sda_sync_reg[2];
  wire stop_det = scl_hi && scl_sync_reg[2] && sda_sync_reg[1] && !sda_sync_reg[2];
  wire sda_in = sda_sync_reg[1];
  wire ack_slot = (bit_reg == 4'd8);
  function automatic logic [7:0] rd_sel(input logic [7:0] p, input logic [7:0] a,
                                         input logic [7:0] b, input logic [7:0] c);
    case (p)
      rcp_pkg::REG_SHARED_CTRL: rd_sel = a;
      rcp_pkg::REG_CH1_VMODE: rd_sel = b;
      rcp_pkg::REG_CH2_VMODE_POR: rd_sel = c;
      default: rd_sel = 8'h00;
    endcase
  endfunction : rd_sel
  wire [7:0] rd_byte = rd_sel(ptr_reg, ctrl_reg, ch1_reg, ch2_reg);
  wire [7:0] rx_byte = {shift_reg[6:0], sda_in};
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
      bit_reg <= 4'd0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ctrl_reg <= rcp_pkg::RESET_SHARED_CTRL;
      ch1_reg <= rcp_pkg::RESET_CH1;
      ch2_reg <= rcp_pkg::RESET_CH2;
      sda_low_reg <= 1'b0;
      dir_reg <= 1'b0;
      got_ptr_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= S_ADDR;
      // first clock fall after a start carries no bit
      bit_reg <= 4'hf;
      sda_low_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= S_IDLE;
      sda_low_reg <= 1'b0;
    end else if (state_reg != S_IDLE && state_reg != S_IGN) begin
      if (scl_rise && !ack_slot && state_reg != S_SEND) begin
        shift_reg <= rx_byte;
      end
      if (scl_rise && ack_slot) begin
        ack_ok_reg <= !sda_in;
      end
      if (scl_fall) begin
        if (bit_reg == 4'd7) begin
          bit_reg <= 4'd8;
          sda_low_reg <= 1'b0;
          unique case (state_reg)
            S_ADDR: begin
              if (shift_reg[7:1] == rcp_pkg::DEV_ADDR) begin
                sda_low_reg <= 1'b1;
                dir_reg <= shift_reg[0];
                got_ptr_reg <= 1'b0;
              end else begin
                state_reg <= S_IGN;
              end
            end
            S_PTR: begin
              ptr_reg <= shift_reg;
              sda_low_reg <= 1'b1;
            end
            S_DATA: begin
              sda_low_reg <= 1'b1;
              unique case (ptr_reg)
                rcp_pkg::REG_SHARED_CTRL: ctrl_reg <= shift_reg;
                rcp_pkg::REG_CH1_VMODE: ch1_reg <= shift_reg;
                rcp_pkg::REG_CH2_VMODE_POR: ch2_reg <= shift_reg;
                default: ;
              endcase
            end
            default: ;
          endcase
        end else if (ack_slot) begin
          bit_reg <= 4'd0;
          sda_low_reg <= 1'b0;
          if (state_reg == S_ADDR) begin
            state_reg <= (dir_reg == rcp_pkg::DIR_READ) ? S_SEND : S_PTR;
            if (dir_reg == rcp_pkg::DIR_READ) begin
              shift_reg <= rd_byte << 1;
              sda_low_reg <= !rd_byte[7];
            end
          end else if (state_reg == S_PTR) begin
            state_reg <= S_DATA;
          end else if (state_reg == S_SEND) begin
            if (ack_ok_reg) begin
              shift_reg <= rd_byte << 1;
              sda_low_reg <= !rd_byte[7];
            end else begin
              state_reg <= S_IGN;
            end
          end
        end else begin
          bit_reg <= bit_reg + 4'd1;
          if (state_reg == S_SEND) begin
            sda_low_reg <= !shift_reg[7];
            shift_reg <= shift_reg << 1;
          end
        end
      end
    end
  end
  // keep shift register for send path coherent: sample ignored while sending
  assign link.sda_o_d = 1'b0;
  assign link.sda_oe_d = sda_low_reg;
  assign o_shared_ctrl = ctrl_reg;
  assign o_ch1_vmode = ch1_reg;
  assign o_ch2_vmode_por = ch2_reg;
  assign o_bus_busy = busy_reg;
endmodule : rcp_device

// file: rcp_master.sv
// master end: apb-driven two-wire master for register write and read
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
module rcp_master (
  // system
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // link
  rcp_link_if.master link
);
  typedef enum logic [3:0] {M_IDLE, M_START, M_BIT, M_ACK, M_RSTART, M_STOP1, M_STOP2}
    rcp_mstate_e;
  rcp_mstate_e st_reg;
  logic [9:0] cnt_reg;
  logic [1:0] byte_reg, phase_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg, ptr_reg, wdata_reg, rdata_reg;
  logic rd_reg, busy_reg, nack_reg, scl_reg, sda_reg, rd_phase_reg;
  logic [31:0] prdata_reg;
  logic [2:0] sda_sync_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) sda_sync_reg <= 3'b111;
    else sda_sync_reg <= {sda_sync_reg[1:0], link.sda};
  end
  wire sda_in = sda_sync_reg[1];
  wire tick = (cnt_reg == 10'(rcp_pkg::HALF_CYCLES - 1));
  wire apb_wr = i_psel && i_penable && i_pwrite;
  wire apb_go = apb_wr && i_paddr == rcp_pkg::APB_CMD && i_pwdata[rcp_pkg::CMD_GO] && !busy_reg;
  // byte to send: 0 addr+w, 1 pointer, 2 data or addr+r
  wire [7:0] next_tx = (byte_reg == 2'd0) ? {rcp_pkg::DEV_ADDR, rcp_pkg::DIR_WRITE} :
                       (byte_reg == 2'd1) ? ptr_reg :
                       rd_phase_reg ? {rcp_pkg::DEV_ADDR, rcp_pkg::DIR_READ} : wdata_reg;
  wire sending = !(rd_phase_reg && byte_reg == 2'd3);
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      unique case (i_paddr)
        rcp_pkg::APB_STATUS: prdata_reg <= {30'h0000_0000, nack_reg, busy_reg};
        rcp_pkg::APB_RDATA: prdata_reg <= {24'h00_0000, rdata_reg};
        rcp_pkg::APB_WDATA: prdata_reg <= {24'h00_0000, wdata_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st_reg <= M_IDLE;
      cnt_reg <= 10'd0;
      byte_reg <= 2'd0;
      phase_reg <= 2'd0;
      bit_reg <= 4'd0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rd_reg <= 1'b0;
      rd_phase_reg <= 1'b0;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      if (apb_wr && i_paddr == rcp_pkg::APB_WDATA && !busy_reg) wdata_reg <= i_pwdata[7:0];
      cnt_reg <= (st_reg == M_IDLE || tick) ? 10'd0 : cnt_reg + 10'd1;
      unique case (st_reg)
        M_IDLE: if (apb_go) begin
          rd_reg <= i_pwdata[rcp_pkg::CMD_READ];
          ptr_reg <= i_pwdata[rcp_pkg::CMD_PTR_LSB +: 8];
          busy_reg <= 1'b1;
          nack_reg <= 1'b0;
          byte_reg <= 2'd0;
          rd_phase_reg <= 1'b0;
          st_reg <= M_START;
        end
        M_START: if (tick) begin
          sda_reg <= 1'b0;
          sh_reg <= next_tx;
          bit_reg <= 4'd0;
          phase_reg <= 2'd0;
          st_reg <= M_BIT;
        end
        M_BIT: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          unique case (phase_reg)
            2'd0: begin
              scl_reg <= 1'b0;
            end
            2'd1: begin
              sda_reg <= sending ? sh_reg[7] : 1'b1;
            end
            2'd2: begin
              scl_reg <= 1'b1;
            end
            2'd3: begin
              sh_reg <= {sh_reg[6:0], sda_in};
              bit_reg <= bit_reg + 4'd1;
              if (bit_reg == 4'd7) st_reg <= M_ACK;
            end
          endcase
        end
        M_ACK: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          unique case (phase_reg)
            2'd0: scl_reg <= 1'b0;
            2'd1: sda_reg <= 1'b1;
            2'd2: scl_reg <= 1'b1;
            2'd3: begin
              if (!sending) begin
                rdata_reg <= sh_reg;
                st_reg <= M_STOP1;
              end else if (sda_in) begin
                nack_reg <= 1'b1;
                st_reg <= M_STOP1;
              end else if (byte_reg == 2'd2 && rd_phase_reg) begin
                byte_reg <= 2'd3;
                sh_reg <= 8'hFF;
                bit_reg <= 4'd0;
                st_reg <= M_BIT;
              end else if (byte_reg == 2'd2) begin
                st_reg <= M_STOP1;
              end else if (byte_reg == 2'd1 && rd_reg) begin
                rd_phase_reg <= 1'b1;
                byte_reg <= 2'd2;
                st_reg <= M_RSTART;
              end else begin
                byte_reg <= byte_reg + 2'd1;
                sh_reg <= (byte_reg == 2'd0) ? ptr_reg : wdata_reg;
                bit_reg <= 4'd0;
                st_reg <= M_BIT;
              end
            end
          endcase
        end
        M_RSTART: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          unique case (phase_reg)
            2'd0: scl_reg <= 1'b0;
            2'd1: sda_reg <= 1'b1;
            2'd2: scl_reg <= 1'b1;
            2'd3: st_reg <= M_START;
          endcase
        end
        M_STOP1: if (tick) begin
          scl_reg <= 1'b0;
          st_reg <= M_STOP2;
          phase_reg <= 2'd0;
        end
        M_STOP2: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          unique case (phase_reg)
            2'd0: sda_reg <= 1'b0;
            2'd1: scl_reg <= 1'b1;
            2'd2: sda_reg <= 1'b1;
            2'd3: begin
              busy_reg <= 1'b0;
              st_reg <= M_IDLE;
            end
          endcase
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end
  assign link.scl_o_m = scl_reg;
  assign link.scl_oe_m = !scl_reg;
  assign link.sda_o_m = sda_reg;
  assign link.sda_oe_m = !sda_reg;
  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
endmodule : rcp_master

// file: rcp_asserts.sv
// checker: link timing and bus state of the master-device pair
`timescale 1ns/1ns
module rcp_asserts (
  // system
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // link and device busy flag
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_d,
  input wire logic o_bus_busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  busy_on_start_a: assert property (start_s |-> ##[1:6] o_bus_busy)
    else $error("busy missing after start");
  busy_off_stop_a: assert property (stop_s |-> ##[1:6] !o_bus_busy)
    else $error("busy stuck after stop");
  dev_edge_low_a: assert property ($changed(sda_oe_d) |-> !scl)
    else $error("device moved data while clock high");
  scl_idle_a: assert property (!o_bus_busy |-> scl)
    else $error("clock low on idle bus");
  dev_busy_only_a: assert property (sda_oe_d |-> o_bus_busy)
    else $error("device drove idle bus");
  ack_width_a: assert property ($rose(sda_oe_d) |-> sda_oe_d [*8])
    else $error("device pulse too short");
  start_quiet_a: assert property (start_s |-> !sda_oe_d [*8])
    else $error("device drove during address");
  scl_high_min_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule : rcp_asserts

// file: rcp_bench.sv
// bench: master and device ends joined, plus a device on a driven link
`timescale 1ns/1ns
module rcp_bench;
  logic i_clk_sys = 0;
  logic i_reset = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] sh, c1, c2, sh2;
  logic busy, busy2;
  logic [7:0] mem [3];
  int err_count = 0;
  int n_compared = 0;
  rcp_link_if lk ();
  rcp_link_if lk2 ();
  rcp_master rcp_master_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(lk));
  rcp_device rcp_device_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(lk),
    .o_shared_ctrl(sh), .o_ch1_vmode(c1), .o_ch2_vmode_por(c2), .o_bus_busy(busy));
  rcp_device rcp_device_fault_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(lk2),
    .o_shared_ctrl(sh2), .o_ch1_vmode(), .o_ch2_vmode_por(), .o_bus_busy(busy2));
  rcp_asserts rcp_asserts_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .scl(lk.scl),
    .sda(lk.sda), .sda_oe_d(lk.sda_oe_d), .o_bus_busy(busy));
  initial begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task final_report();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_rd(input logic [7:0] p);
    return (p < 8'h03) ? mem[p[1:0]] : 8'h00;
  endfunction : exp_rd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    chk({31'h0, pslverr}, 32'h0000_0000);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk_sys);
    if (n >= 20) begin
      err_count++;
      final_report();
    end
  endtask : apb
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    for (n = 0; n < 500; n++) begin
      repeat (40) @(posedge i_clk_sys);
      apb(1'b0, rcp_pkg::APB_STATUS, 32'h0000_0000, r);
      if (r[rcp_pkg::ST_BUSY] === 1'b0) break;
    end
    if (n == 500) begin
      err_count++;
      final_report();
    end
    chk({31'h0, r[rcp_pkg::ST_NACK]}, 32'h0000_0000);
  endtask : wait_idle
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, rcp_pkg::APB_WDATA, {24'h00_0000, d}, r);
    apb(1'b1, rcp_pkg::APB_CMD, {16'h0000, p, 8'h01}, r);
    apb(1'b1, rcp_pkg::APB_WDATA, {24'h00_0000, ~d}, r);
    wait_idle();
    apb(1'b0, rcp_pkg::APB_WDATA, 32'h0000_0000, r);
    chk(r, {24'h00_0000, d});
    if (p < 8'h03) mem[p[1:0]] = d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] p);
    logic [31:0] r;
    apb(1'b1, rcp_pkg::APB_CMD, {16'h0000, p, 8'h03}, r);
    wait_idle();
    apb(1'b0, rcp_pkg::APB_RDATA, 32'h0000_0000, r);
    chk(r, {24'h00_0000, exp_rd(p)});
  endtask : rd_reg
  task automatic bb_bit(input logic v, output logic s);
    repeat (2) @(posedge i_clk_sys);
    lk2.sda_oe_m <= !v;
    repeat (2) @(posedge i_clk_sys);
    lk2.scl_oe_m <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    s = lk2.sda;
    lk2.scl_oe_m <= 1'b1;
  endtask : bb_bit
  task automatic bb_byte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bb_bit(v[i], s);
    bb_bit(1'b1, s);
    chk({31'h0, s}, 32'h0000_0001);
    chk({31'h0, busy2}, 32'h0000_0001);
  endtask : bb_byte
  initial begin
    lk2.scl_o_m = 1'b0;
    lk2.sda_o_m = 1'b0;
    lk2.scl_oe_m = 1'b0;
    lk2.sda_oe_m = 1'b0;
    void'($urandom(32'hb108_12ea));
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    mem[0] = rcp_pkg::RESET_SHARED_CTRL;
    mem[1] = rcp_pkg::RESET_CH1;
    mem[2] = rcp_pkg::RESET_CH2;
    lk2.sda_oe_m <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    lk2.scl_oe_m <= 1'b1;
    bb_byte({rcp_pkg::DEV_ADDR ^ 7'h01, rcp_pkg::DIR_WRITE});
    bb_byte(8'h00);
    bb_byte(8'h5A);
    repeat (2) @(posedge i_clk_sys);
    lk2.sda_oe_m <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    lk2.scl_oe_m <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    lk2.sda_oe_m <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    chk({24'h00_0000, sh2}, {24'h00_0000, rcp_pkg::RESET_SHARED_CTRL});
    chk({31'h0, busy2}, 32'h0000_0000);
    for (int p = 3; p >= 0; p--) wr_reg(p[7:0], 8'($urandom));
    chk({8'h00, sh, c1, c2}, {8'h00, mem[0], mem[1], mem[2]});
    for (int p = 0; p < 4; p++) rd_reg(p[7:0]);
    wr_reg(8'h01, 8'h80);
    rd_reg(8'h01);
    final_report();
  end
endmodule : rcp_bench
